// ==== design/fcpm_top.sv ====
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fcpm_top
   import fcpm_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   output var  logic [NUM_CH-1:0] pulse_out,
   output var  logic [NUM_CH-1:0] pulse_oe
);

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   fcpm_regs_type     regs_q;
   fcpm_regs_type     regs_d;
   fcpm_apb_resp_type resp_q;
   fcpm_apb_resp_type resp_d;
   logic [7:0]        count_q;
   logic [7:0]        count_d;
   logic [8:0]        div_q;
   logic [8:0]        div_d;
   logic [NUM_CH-1:0] run_en;
   logic [NUM_CH-1:0] drive_en;
   logic [NUM_CH-1:0] out_q;
   logic [NUM_CH-1:0] out_d;
   logic [NUM_CH-1:0] oe_q;
   logic [NUM_CH-1:0] oe_d;
   logic [7:0]        idx;
   logic              aligned;
   logic              do_write;
   logic [8:0]        div_last;

   assign idx      = paddr[ADDR_W-1:2];
   assign aligned  = (paddr[1:0] == 2'h0);
   assign do_write = psel && penable && resp_q.ready && pwrite && pstrb[0];

   always_comb begin
      resp_d = '0;
      if (psel && !penable) begin
         resp_d.ready = 1'b1;
         if (!aligned) begin
            resp_d.slverr = 1'b1;
         end else begin
            unique case (idx)
               IDX_CTRL_CH4:   resp_d.rdata[7:0] = regs_q.ctrl_high;
               IDX_DUTY_CH4:   resp_d.rdata[7:0] = regs_q.duty[4];
               IDX_PRESCALE:   resp_d.rdata[7:0] = regs_q.prescale;
               IDX_DUTY_CH0:   resp_d.rdata[7:0] = regs_q.duty[0];
               IDX_DUTY_CH1:   resp_d.rdata[7:0] = regs_q.duty[1];
               IDX_CTRL_CH0_3: resp_d.rdata[7:0] = regs_q.ctrl_low;
               IDX_DUTY_CH2:   resp_d.rdata[7:0] = regs_q.duty[2];
               IDX_DUTY_CH3:   resp_d.rdata[7:0] = regs_q.duty[3];
               IDX_COUNT_STAT: begin
                  resp_d.rdata[7:0] = count_q;
                  resp_d.slverr     = pwrite;
               end
               default:        resp_d.slverr = 1'b1;
            endcase
         end
      end
   end

   always_comb begin
      regs_d = regs_q;
      if (do_write && aligned) begin
         unique case (idx)
            IDX_CTRL_CH4: begin
               regs_d.ctrl_high                = RST_CTRL;
               regs_d.ctrl_high[CH4_RUN_BIT]   = pwdata[CH4_RUN_BIT];
               regs_d.ctrl_high[CH4_DRIVE_BIT] = pwdata[CH4_DRIVE_BIT];
            end
            IDX_DUTY_CH4:   regs_d.duty[4]   = pwdata[7:0];
            IDX_PRESCALE:   regs_d.prescale  = pwdata[7:0];
            IDX_DUTY_CH0:   regs_d.duty[0]   = pwdata[7:0];
            IDX_DUTY_CH1:   regs_d.duty[1]   = pwdata[7:0];
            IDX_CTRL_CH0_3: regs_d.ctrl_low  = pwdata[7:0];
            IDX_DUTY_CH2:   regs_d.duty[2]   = pwdata[7:0];
            IDX_DUTY_CH3:   regs_d.duty[3]   = pwdata[7:0];
            default:        regs_d = regs_q;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regs_q.prescale  <= RST_PRESCALE;
         regs_q.ctrl_low  <= RST_CTRL;
         regs_q.ctrl_high <= RST_CTRL;
         regs_q.duty      <= {NUM_CH{RST_DUTY}};
         resp_q           <= '0;
      end else begin
         regs_q <= regs_d;
         resp_q <= resp_d;
      end
   end

   // ----------------------------------------
   // Shared prescaler and counter
   // ----------------------------------------
   // Step every 2 x (prescale + 1) clocks
   assign div_last = 9'(OSC_DIVIDE * ({1'b0, regs_q.prescale} + 9'h001) - 9'h001);

   always_comb begin
      div_d   = div_q;
      count_d = count_q;
      if (run_en == '0) begin
         div_d   = '0;
         count_d = '0;
      end else if (div_q >= div_last) begin
         div_d   = '0;
         count_d = (count_q >= COUNT_LAST) ? 8'h00 : 8'(count_q + 8'h01);
      end else begin
         div_d = 9'(div_q + 9'h001);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q   <= '0;
         count_q <= '0;
      end else begin
         div_q   <= div_d;
         count_q <= count_d;
      end
   end

   // ----------------------------------------
   // Channels
   // ----------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         if (ch < NUM_CH - 1) begin : g_low
            localparam int RUN_POS = (ch / 2) * LOW_PAIR_STRIDE + (ch % 2);
            assign run_en[ch]   = regs_q.ctrl_low[RUN_POS];
            assign drive_en[ch] = regs_q.ctrl_low[RUN_POS + LOW_DRIVE_OFS];
         end else begin : g_high
            assign run_en[ch]   = regs_q.ctrl_high[CH4_RUN_BIT];
            assign drive_en[ch] = regs_q.ctrl_high[CH4_DRIVE_BIT];
         end
         // Compare against live register, so new values act at once
         always_comb begin
            oe_d[ch]  = run_en[ch] && drive_en[ch];
            out_d[ch] = 1'b1;
            if (run_en[ch] && drive_en[ch]) begin
               out_d[ch] = (regs_q.duty[ch] > count_q);
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= {NUM_CH{1'b1}};
         oe_q  <= '0;
      end else begin
         out_q <= out_d;
         oe_q  <= oe_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata    = resp_q.rdata;
   assign pready    = resp_q.ready;
   assign pslverr   = resp_q.slverr;
   assign pulse_out = out_q;
   assign pulse_oe  = oe_q;

endmodule
`default_nettype wire

// ==== pkg/fcpm_pkg.sv ====
// Function
// - Five channels, each with an 8-bit compare register, share one counter.
// - An 8-bit prescaler divides the counter step by prescaler plus one.
// - Prescaler and counter are shared, so all channels share one period.
// - Counter runs 0 to 254, then wraps to 0.
// - Output high while compare exceeds count, low otherwise.
// - Counter advances once every 2 x (prescaler + 1) clocks.
// - Duty runs 0 to 1 in 1/255 steps.
// - Compare 00h and ffh give constant levels; ffh is never equalled.
// - A new compare value affects the output at once.
// - First control register holds run and drive enables of channels 0 to 3.
// - Second control register holds run and drive enables of channel 4.
// - Each channel pin rests at a weak pull-up high level.
package fcpm_pkg;

   // ----------------------------------------
   // Register indices, byte address = 4 x index
   // ----------------------------------------
   localparam logic [7:0] IDX_CTRL_CH4    = 8'hce;
   localparam logic [7:0] IDX_DUTY_CH4    = 8'hcf;
   localparam logic [7:0] IDX_PRESCALE    = 8'hd9;
   localparam logic [7:0] IDX_DUTY_CH0    = 8'hda;
   localparam logic [7:0] IDX_DUTY_CH1    = 8'hdb;
   localparam logic [7:0] IDX_CTRL_CH0_3  = 8'hdc;
   localparam logic [7:0] IDX_DUTY_CH2    = 8'hdd;
   localparam logic [7:0] IDX_DUTY_CH3    = 8'hde;
   localparam logic [7:0] IDX_COUNT_STAT  = 8'he0;

   localparam int         ADDR_W          = 10;
   localparam int         NUM_CH          = 5;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int         CH4_RUN_BIT     = 0;
   localparam int         CH4_DRIVE_BIT   = 2;
   localparam int         LOW_DRIVE_OFS   = 2;
   localparam int         LOW_PAIR_STRIDE = 4;

   // ----------------------------------------
   // Reset values and counts
   // ----------------------------------------
   localparam logic [7:0] RST_DUTY        = 8'h00;
   localparam logic [7:0] RST_PRESCALE    = 8'h00;
   localparam logic [7:0] RST_CTRL        = 8'h00;
   localparam logic [7:0] COUNT_LAST      = 8'hfe;
   localparam logic [8:0] OSC_DIVIDE      = 9'h002;

   typedef struct packed {
      logic [7:0]             prescale;
      logic [7:0]             ctrl_low;
      logic [7:0]             ctrl_high;
      logic [NUM_CH-1:0][7:0] duty;
   } fcpm_regs_type;

   typedef struct packed {
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
   } fcpm_apb_resp_type;

endpackage

// ==== verif/fcpm_load.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcpm_load
   import fcpm_pkg::*;
(
   input  wire logic [NUM_CH-1:0] pulse_out,
   input  wire logic [NUM_CH-1:0] pulse_oe,
   output var  logic [NUM_CH-1:0] pin
);
   // ------------------
   // Pull-up when idle
   // ------------------
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         pin[c] = pulse_oe[c] ? pulse_out[c] : 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== verif/fcpm_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcpm_tb
   import fcpm_pkg::*;
;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0;
   logic [3:0]        pstrb = 4'hf;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [NUM_CH-1:0] pulse_out;
   logic [NUM_CH-1:0] pulse_oe;
   logic [NUM_CH-1:0] pin;
   logic [31:0]       rd;
   logic              err;
   logic [7:0]        v;
   int                mismatches = 0;
   int                n_checks = 0;
   int                hi [NUM_CH];
   logic [7:0]        ix [8] = '{IDX_DUTY_CH4, IDX_PRESCALE, IDX_DUTY_CH0, IDX_DUTY_CH1,
                                 IDX_DUTY_CH2, IDX_DUTY_CH3, IDX_CTRL_CH0_3, IDX_CTRL_CH4};
   logic [7:0]        dix [NUM_CH] = '{IDX_DUTY_CH0, IDX_DUTY_CH1, IDX_DUTY_CH2,
                                       IDX_DUTY_CH3, IDX_DUTY_CH4};
   logic [7:0]        duty [NUM_CH] = '{8'h00, 8'h80, 8'h20, 8'hff, 8'hfe};
   always #12.5 pclk = ~pclk;
   fcpm_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
                 .prdata, .pready, .pslverr, .pulse_out, .pulse_oe);
   fcpm_load load (.pulse_out, .pulse_oe, .pin);
   // ------------------
   // Tasks
   // ------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {a, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         mismatches++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_pin(input int c, input logic lvl, output int n);
      n = 0;
      while (pin[c] !== lvl && n < 4000) begin
         @(posedge pclk);
         n++;
      end
      if (pin[c] !== lvl) begin
         mismatches++;
         report_and_stop();
      end
   endtask
   task automatic run(input logic [7:0] p);
      int w;
      bus(1'b1, IDX_PRESCALE, p);
      repeat (4) @(posedge pclk);
      hi = '{default: 0};
      repeat (510 * (p + 1)) begin
         @(posedge pclk);
         for (int c = 0; c < NUM_CH; c++) hi[c] += int'(pin[c] === 1'b1);
      end
      for (int c = 0; c < NUM_CH; c++) chk("high count", 32'(hi[c]), 32'(duty[c]) * 2 * (p + 1));
      // One high pulse of channel 1 fixes the step rate
      wait_pin(1, 1'b0, w);
      wait_pin(1, 1'b1, w);
      wait_pin(1, 1'b0, w);
      chk("high run", 32'(w), 32'(duty[1]) * 2 * (p + 1));
   endtask
   // ------------------
   // Sequence
   // ------------------
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      bus(1'b0, IDX_COUNT_STAT, 8'h00);
      chk("idle count", rd, 32'h0);
      chk("status read ok", {31'h0, err}, 32'h0);
      bus(1'b1, IDX_COUNT_STAT, 8'h12);
      chk("status write error", {31'h0, err}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         v = 8'ha5 ^ 8'(i);
         bus(1'b0, ix[i], 8'h00);
         chk("reset value", rd, 32'h0);
         bus(1'b1, ix[i], v);
         bus(1'b0, ix[i], 8'h00);
         chk("readback", rd, {24'h0, (ix[i] == IDX_CTRL_CH4) ? (v & 8'h05) : v});
      end
      pstrb <= 4'he;
      bus(1'b1, IDX_DUTY_CH0, 8'h11);
      pstrb <= 4'hf;
      bus(1'b0, IDX_DUTY_CH0, 8'h00);
      chk("masked write", rd, 32'h0000_00a7);
      bus(1'b0, 8'h00, 8'h00);
      chk("unmapped error", {31'h0, err}, 32'h1);
      bus(1'b1, IDX_CTRL_CH0_3, 8'h00);
      bus(1'b1, IDX_CTRL_CH4, 8'h00);
      for (int c = 0; c < NUM_CH; c++) bus(1'b1, dix[c], duty[c]);
      bus(1'b1, IDX_PRESCALE, 8'h00);
      bus(1'b1, IDX_CTRL_CH0_3, 8'h33);
      bus(1'b1, IDX_CTRL_CH4, 8'h01);
      repeat (2) @(posedge pclk);
      #1;
      chk("oe while run only", {27'h0, pulse_oe}, 32'h0);
      chk("pin idle", {27'h0, pin}, 32'h1f);
      bus(1'b1, IDX_CTRL_CH0_3, 8'hff);
      bus(1'b1, IDX_CTRL_CH4, 8'h05);
      run(8'h00);
      run(8'h01);
      bus(1'b1, IDX_DUTY_CH3, 8'h00);
      repeat (2) @(posedge pclk);
      #1;
      chk("duty update", {31'h0, pin[3]}, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire

// ==== verif/fcpm_top_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcpm_top_sva
   import fcpm_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [NUM_CH-1:0] pulse_out,
   input wire logic [NUM_CH-1:0] pulse_oe
);
   // ------------------
   // Checks
   // ------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc_w;
   assign acc_w = psel && penable && pwrite && pready && pstrb[0];
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_bad_addr_err: assert property (psel && !penable
      && (paddr[1:0] != 2'h0 || paddr[9:2] == 8'h00) |=> pready && pslverr)
      else $error("bad address not refused");
   a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_idle_pullup: assert property (&(pulse_out | pulse_oe))
      else $error("undriven pin not high");
   a_oe_cause: assert property ($changed(pulse_oe) |-> $past(acc_w, 2))
      else $error("drive enable changed without write");
   a_low_drive: assert property (acc_w && paddr == {IDX_CTRL_CH0_3, 2'h0} |->
      ##2 pulse_oe[0] == $past(pwdata[0] & pwdata[2], 2))
      else $error("channel 0 drive mismatch");
   a_high_drive: assert property (acc_w && paddr == {IDX_CTRL_CH4, 2'h0} |->
      ##2 pulse_oe[4] == $past(pwdata[0] & pwdata[2], 2))
      else $error("channel 4 drive mismatch");
   c_write: cover property (acc_w);
   c_refused: cover property (pready && pslverr);
   c_ch4_on: cover property ($rose(pulse_oe[4]));
endmodule
bind fcpm_top fcpm_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pready, .pslverr, .pulse_out, .pulse_oe);
`default_nettype wire
